// ### wsc_pkg.sv
// Constants, field layouts and carrier types for the watchdog and sleep controller.
// Function
// - Awake watchdog expiry forces a recorded device reset
// - Asleep watchdog expiry wakes and resumes execution
// - Cleared fuse bit keeps the watchdog disabled
// - Watchdog counts its own oscillator, also asleep
// - Unprescaled time-out is one base period
// - Option register assigns divider up to 128
// - Kick or sleep clears counter, and divider when it is assigned to the watchdog
// - Kick never changes the divider owner selection
// - After sleep executes, expiry only wakes, never resets
// - Every watchdog time-out clears the expiry flag
// - Sleep clears watchdog and sleep flag, sets expiry flag, stops main oscillator
// - Pins keep their pre-sleep state while asleep
// - Wake on master clear, expiry or interrupt
// - Sleep flag set at power-up, cleared by sleep
// - Phase clocks stop; only clockless sources wake
// - Interrupt wake needs enable, ignores global enable
// - Run next instruction, then vector if enabled
// - Next instruction is prefetched during sleep execution
// - Pending enabled interrupt turns sleep into no-op
// - Interrupt during sleep: finish sleep, then wake
// - Global enable is bit 7, cleared on reset
package wsc_pkg;

   // ==========================================================================
   // Register map
   localparam int ADDR_W = 14;
   localparam logic [13:0] ADDR_STATUS = 14'h0003;
   localparam logic [13:0] ADDR_IRQ_CTRL = 14'h000b;
   localparam logic [13:0] ADDR_IRQ_FLAGS = 14'h000c;
   localparam logic [13:0] ADDR_WAKE_EN = 14'h008c;
   localparam logic [13:0] ADDR_WDT_STATE = 14'h0010;
   localparam logic [13:0] ADDR_TIMER_OPTION = 14'h0081;
   localparam logic [13:0] ADDR_CONFIG_WORD = 14'h2007;

   // ==========================================================================
   // Field positions and reset values
   localparam int CFG_WDT_FUSE_BIT = 2;
   localparam int IRQ_GLOBAL_EN_BIT = 7;
   localparam int STATE_WDT_ON_BIT = 7;
   localparam int STATE_SLEEP_BIT = 6;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] WAKE_EN_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   // Sources able to raise a flag without phase clocks (async timer, slave serial, capture).
   localparam logic [7:0] WAKE_CAPABLE_MASK = 8'hf0;

   // ==========================================================================
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int WDT_BASE_PERIOD_US = 18_000;
   localparam int WDT_CNT_W = 20;
   localparam int PRE_W = 7;
   localparam int RESET_HOLD_NS = 40;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int HOLD_W = 4;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic [3:0] timer_bits;
      logic prescaler_owner_sel;
      logic [2:0] divider_ratio_sel;
   } wsc_option_t;

   typedef struct packed {
      logic [2:0] upper_bits;
      logic wdt_expiry_flag_n;
      logic sleep_entered_flag_n;
      logic [2:0] lower_bits;
   } wsc_status_t;

endpackage

// ### wsc_watchdog_sleep.sv
// Watchdog timer with divider and power-down sequencing for a small core.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module wsc_watchdog_sleep
   import wsc_pkg::*;
#(
   parameter int RC_OSC_KHZ = 1000,
   parameter int WDT_BASE_TICKS = WDT_BASE_PERIOD_US * RC_OSC_KHZ / 1000
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [13:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_we_in,
   input wire logic reg_re_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [7:0] config_word_in,
   input wire logic wdt_osc_in,
   input wire logic master_clear_pin_n_in,
   input wire logic kick_instr_in,
   input wire logic sleep_instr_in,
   input wire logic [7:0] irq_flags_in,
   output logic device_reset_out,
   output logic wdt_reset_cause_out,
   output logic main_osc_en_out,
   output logic phase_clk_en_out,
   output logic io_hold_out,
   output logic sleeping_out,
   output logic wake_out,
   output logic wake_vector_out,
   output logic prefetch_out,
   output logic prescaler_to_timer_out
);

   // ==========================================================================
   // Local constants
   localparam logic [WDT_CNT_W-1:0] WDT_LAST = WDT_CNT_W'(WDT_BASE_TICKS - 1);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_HOLD_CYCLES);

   // ==========================================================================
   // State
   logic rc_meta_q;
   logic rc_sync_q;
   logic rc_prev_q;
   logic master_clear_pin_n_meta_q;
   logic master_clear_pin_n_sync_q;
   logic cfg_valid_q;
   logic [7:0] cfg_q;
   wsc_option_t option_q;
   wsc_status_t status_q;
   logic global_irq_enable_q;
   logic [7:0] wake_en_q;
   logic [WDT_CNT_W-1:0] wdt_cnt_q;
   logic [WDT_CNT_W-1:0] wdt_cnt_d;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic [HOLD_W-1:0] hold_q;
   logic [HOLD_W-1:0] hold_d;
   logic sleeping_q;
   logic sleeping_d;
   logic [7:0] rdata_q;
   logic reset_q;
   logic cause_q;
   logic osc_en_q;
   logic phase_en_q;
   logic io_hold_q;
   logic sleeping_out_q;
   logic wake_q;
   logic vector_q;
   logic prefetch_q;
   logic owner_timer_q;

   // ==========================================================================
   // Synchronisers for the watchdog oscillator and the master clear pin
   // The oscillator is free running and unrelated to clk_in, so only its
   // synchronised rising edge is counted; it must stay below a quarter of clk_in.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rc_meta_q <= 1'b0;
         rc_sync_q <= 1'b0;
         rc_prev_q <= 1'b0;
         master_clear_pin_n_meta_q <= 1'b1;
         master_clear_pin_n_sync_q <= 1'b1;
      end else begin
         rc_meta_q <= wdt_osc_in;
         rc_sync_q <= rc_meta_q;
         rc_prev_q <= rc_sync_q;
         master_clear_pin_n_meta_q <= master_clear_pin_n_in;
         master_clear_pin_n_sync_q <= master_clear_pin_n_meta_q;
      end
   end

   wire rc_tick = rc_sync_q & ~rc_prev_q;
   wire master_clear_pin_n_low = ~master_clear_pin_n_sync_q;

   // ==========================================================================
   // Configuration word, caught once after power-up reset is released
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_valid_q <= 1'b0;
         cfg_q <= CONFIG_RESET;
      end else if (!cfg_valid_q) begin
         cfg_valid_q <= 1'b1;
         cfg_q <= config_word_in;
      end
   end

   // The fuse is caught once, so a disturbed pin cannot switch the
   // watchdog off while the core runs.
   wire wdt_on = cfg_valid_q & cfg_q[CFG_WDT_FUSE_BIT];

   // ==========================================================================
   // Register decode
   wire in_reset = (hold_q != '0);
   wire sel_status = (reg_addr_in == ADDR_STATUS);
   wire sel_irq_ctrl = (reg_addr_in == ADDR_IRQ_CTRL);
   wire sel_irq_flags = (reg_addr_in == ADDR_IRQ_FLAGS);
   wire sel_wake_en = (reg_addr_in == ADDR_WAKE_EN);
   wire sel_wdt_state = (reg_addr_in == ADDR_WDT_STATE);
   wire sel_option = (reg_addr_in == ADDR_TIMER_OPTION);
   wire sel_config = (reg_addr_in == ADDR_CONFIG_WORD);
   wire wr_option = reg_we_in & sel_option;
   wire wr_irq_ctrl = reg_we_in & sel_irq_ctrl;
   wire wr_wake_en = reg_we_in & sel_wake_en;

   wire [7:0] irq_ctrl_rd = {global_irq_enable_q, 7'h00};
   wire [7:0] wdt_state_rd = {wdt_on, sleeping_q, 6'h00};
   // Read data fall back to zero outside the read cycle, so no stale
   // value lingers on the bus.
   wire [7:0] rd_mux = sel_status ? status_q :
                       sel_irq_ctrl ? irq_ctrl_rd :
                       sel_irq_flags ? irq_flags_in :
                       sel_wake_en ? wake_en_q :
                       sel_wdt_state ? wdt_state_rd :
                       sel_option ? option_q :
                       sel_config ? cfg_q : 8'h00;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_re_in ? rd_mux : 8'h00;
      end
   end

   // ==========================================================================
   // Wake sources, one gate per interrupt line
   // While asleep only lines that work without phase clocks may wake the core;
   // the global enable plays no part in waking.
   logic [7:0] wake_hit;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_wake
         assign wake_hit[gi] = irq_flags_in[gi] & wake_en_q[gi] &
                               (WAKE_CAPABLE_MASK[gi] | ~sleeping_q);
      end
   endgenerate

   wire wake_any = |wake_hit;

   // ==========================================================================
   // Sleep entry and watchdog clearing
   // A sleep that meets a master clear is dropped, so no prefetch pulse
   // announces an entry that the reset cancels at once.
   wire sleep_start = sleep_instr_in & ~sleeping_q & ~in_reset & ~master_clear_pin_n_low;
   wire sleep_nop = sleep_start & wake_any;
   wire sleep_take = sleep_start & ~sleep_nop;
   wire kick = kick_instr_in & ~sleeping_q & ~in_reset;
   // A kick or sleep in the expiry cycle wins; the hold clears the count
   // too, so no second expiry can land inside a reset.
   wire wdt_clear = kick | sleep_take | ~wdt_on | in_reset;

   // ==========================================================================
   // Watchdog counter and divider
   wire base_done = wdt_on & rc_tick & (wdt_cnt_q == WDT_LAST);
   wire owner_wdt = option_q.prescaler_owner_sel;
   // The divider ends at a count of two to the n minus one, so a ratio
   // field of zero divides by one and seven by 128.
   wire [7:0] ratio_full = (8'h01 << option_q.divider_ratio_sel) - 8'h01;
   wire [PRE_W-1:0] ratio_last = ratio_full[PRE_W-1:0];
   wire pre_done = ~owner_wdt | (pre_q == ratio_last);
   wire expire = base_done & pre_done & ~wdt_clear;
   wire expire_reset = expire & ~sleeping_q;
   wire expire_wake = expire & sleeping_q;
   wire irq_wake = sleeping_q & wake_any & ~master_clear_pin_n_low;
   // A master clear in the wake cycle turns the wake into a reset instead.
   wire wake_go = (expire_wake | irq_wake) & ~master_clear_pin_n_low;

   // An expiry restarts the count at once, so a wake-up from sleep
   // opens a full fresh period.
   always_comb begin
      wdt_cnt_d = wdt_cnt_q;
      if (wdt_clear || expire) begin
         wdt_cnt_d = '0;
      end else if (wdt_on && rc_tick) begin
         wdt_cnt_d = (wdt_cnt_q == WDT_LAST) ? '0 : wdt_cnt_q + 1'b1;
      end
   end

   // A kick or sleep clears the divider count only while it belongs to the watchdog,
   // but the reset hold or an expiry always clears it; a kick leaves the owner selection alone.
   always_comb begin
      pre_d = pre_q;
      if (in_reset || expire || (wdt_clear && owner_wdt)) begin
         pre_d = '0;
      end else if (base_done && owner_wdt) begin
         pre_d = pre_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wdt_cnt_q <= '0;
         pre_q <= '0;
      end else begin
         wdt_cnt_q <= wdt_cnt_d;
         pre_q <= pre_d;
      end
   end

   // ==========================================================================
   // Device reset hold
   // A master clear held low keeps reloading the hold count, so the reset
   // output lasts for the whole low time plus the minimum hold.
   always_comb begin
      hold_d = hold_q;
      if (master_clear_pin_n_low || expire_reset) begin
         hold_d = HOLD_LOAD;
      end else if (in_reset) begin
         hold_d = hold_q - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hold_q <= '0;
         reset_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         reset_q <= (hold_d != '0);
      end
   end

   // The cause stays visible until the next reset of another kind begins.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cause_q <= 1'b0;
      end else if (expire_reset) begin
         cause_q <= 1'b1;
      end else if (master_clear_pin_n_low) begin
         cause_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Sleep state
   // Master clear beats every other cause, since it leads straight
   // into a device reset.
   always_comb begin
      sleeping_d = sleeping_q;
      if (master_clear_pin_n_low || expire_wake || irq_wake) begin
         sleeping_d = 1'b0;
      end else if (sleep_take) begin
         sleeping_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sleeping_q <= 1'b0;
         sleeping_out_q <= 1'b0;
         osc_en_q <= 1'b1;
         phase_en_q <= 1'b1;
         io_hold_q <= 1'b0;
      end else begin
         sleeping_q <= sleeping_d;
         sleeping_out_q <= sleeping_d;
         osc_en_q <= ~sleeping_d;
         phase_en_q <= ~sleeping_d;
         io_hold_q <= sleeping_d;
      end
   end

   // ==========================================================================
   // Wake and prefetch pulses toward the core
   // The core runs the prefetched instruction first and takes the vector
   // only after it, so the vector pulse marks a pending branch, not a jump now.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wake_q <= 1'b0;
         vector_q <= 1'b0;
         prefetch_q <= 1'b0;
      end else begin
         wake_q <= wake_go;
         vector_q <= irq_wake & global_irq_enable_q;
         prefetch_q <= sleep_take;
      end
   end

   // ==========================================================================
   // Status flags
   // Both flags survive device resets so that software can tell the cause;
   // only power-up sets both again, and sleep entry also sets the expiry flag.
   // Expiry and sleep entry never meet here, because a sleep clears
   // the count in the same cycle.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status_q <= '0;
         status_q.wdt_expiry_flag_n <= 1'b1;
         status_q.sleep_entered_flag_n <= 1'b1;
      end else if (expire) begin
         status_q.wdt_expiry_flag_n <= 1'b0;
      end else if (sleep_take) begin
         status_q.wdt_expiry_flag_n <= 1'b1;
         status_q.sleep_entered_flag_n <= 1'b0;
      end
   end

   // ==========================================================================
   // Software registers
   // The reset hold sets these back as a power-up would; the status
   // flags stay so that software can read the cause.
   always_ff @(posedge clk_in) begin
      if (rst_in || in_reset) begin
         option_q <= OPTION_RESET;
      end else if (wr_option) begin
         option_q <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || in_reset) begin
         global_irq_enable_q <= 1'b0;
      end else if (wr_irq_ctrl) begin
         global_irq_enable_q <= reg_wdata_in[IRQ_GLOBAL_EN_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || in_reset) begin
         wake_en_q <= WAKE_EN_RESET;
      end else if (wr_wake_en) begin
         wake_en_q <= reg_wdata_in;
      end
   end

   // The owner output lags the option register by one cycle; the
   // timer side only needs it as a level.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         owner_timer_q <= 1'b0;
      end else begin
         owner_timer_q <= ~option_q.prescaler_owner_sel;
      end
   end

   // ==========================================================================
   // Outputs
   // Every output is a flip-flop, so the core sees no decode glitches.
   assign reg_rdata_out = rdata_q;
   assign device_reset_out = reset_q;
   assign wdt_reset_cause_out = cause_q;
   assign main_osc_en_out = osc_en_q;
   assign phase_clk_en_out = phase_en_q;
   assign io_hold_out = io_hold_q;
   assign sleeping_out = sleeping_out_q;
   assign wake_out = wake_q;
   assign wake_vector_out = vector_q;
   assign prefetch_out = prefetch_q;
   assign prescaler_to_timer_out = owner_timer_q;

endmodule // wsc_watchdog_sleep

// ### wsc_watchdog_sleep_asserts.sv
// Port-level assertions for the watchdog and sleep controller.
`timescale 1ns/1ps

module wsc_watchdog_sleep_asserts
   import wsc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [13:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_we_in,
   input wire logic reg_re_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [7:0] config_word_in,
   input wire logic master_clear_pin_n_in,
   input wire logic sleep_instr_in,
   input wire logic device_reset_out,
   input wire logic wdt_reset_cause_out,
   input wire logic main_osc_en_out,
   input wire logic phase_clk_en_out,
   input wire logic io_hold_out,
   input wire logic sleeping_out,
   input wire logic wake_out,
   input wire logic wake_vector_out,
   input wire logic prefetch_out,
   input wire logic prescaler_to_timer_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // ==========================================================================
   // Properties
   property p_enter;
      prefetch_out |-> sleeping_out && $past(sleep_instr_in) && !$past(sleeping_out);
   endproperty
   a_enter: assert property (p_enter) else $error("prefetch without sleep entry");
   property p_rose;
      $rose(sleeping_out) |-> prefetch_out && io_hold_out;
   endproperty
   a_rose: assert property (p_rose) else $error("sleep entry incomplete");
   property p_asleep;
      sleeping_out |-> !main_osc_en_out && !phase_clk_en_out && io_hold_out;
   endproperty
   a_asleep: assert property (p_asleep) else $error("clocks or pins live in sleep");
   property p_wake;
      wake_out |-> $past(sleeping_out) && !device_reset_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without sleep");
   property p_vec;
      wake_vector_out |-> wake_out;
   endproperty
   a_vec: assert property (p_vec) else $error("vector without wake");
   property p_rd;
      !$past(reg_re_in) |-> reg_rdata_out == 8'h00;
   endproperty
   a_rd: assert property (p_rd) else $error("read data outside its cycle");
   property p_fuse;
      !config_word_in[CFG_WDT_FUSE_BIT] |-> !wdt_reset_cause_out;
   endproperty
   a_fuse: assert property (p_fuse) else $error("watchdog reset with fuse off");
   property p_hold;
      $rose(device_reset_out) && master_clear_pin_n_in && $past(master_clear_pin_n_in)
         && $past(master_clear_pin_n_in, 2) && $past(master_clear_pin_n_in, 3)
         |-> device_reset_out [*4] ##1 !device_reset_out;
   endproperty
   a_hold: assert property (p_hold) else $error("reset hold length wrong");
   property p_opt;
      reg_we_in && reg_addr_in == ADDR_TIMER_OPTION && !device_reset_out |-> ##2
         (device_reset_out || prescaler_to_timer_out == !$past(reg_wdata_in[3], 2));
   endproperty
   a_opt: assert property (p_opt) else $error("divider owner not applied");

   c_sleep: cover property (prefetch_out);
   c_vector: cover property (wake_vector_out);
   c_wdt_reset: cover property ($rose(wdt_reset_cause_out));
endmodule // wsc_watchdog_sleep_asserts

bind wsc_watchdog_sleep wsc_watchdog_sleep_asserts i_wsc_watchdog_sleep_asserts (
   .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in), .reg_re_in(reg_re_in),
   .reg_rdata_out(reg_rdata_out), .config_word_in(config_word_in),
   .master_clear_pin_n_in(master_clear_pin_n_in), .sleep_instr_in(sleep_instr_in),
   .device_reset_out(device_reset_out), .wdt_reset_cause_out(wdt_reset_cause_out),
   .main_osc_en_out(main_osc_en_out), .phase_clk_en_out(phase_clk_en_out),
   .io_hold_out(io_hold_out), .sleeping_out(sleeping_out), .wake_out(wake_out),
   .wake_vector_out(wake_vector_out), .prefetch_out(prefetch_out),
   .prescaler_to_timer_out(prescaler_to_timer_out));

// ### wsc_watchdog_sleep_tb.sv
// Self-checking bench for the watchdog and sleep controller.
`timescale 1ns/1ps

module wsc_watchdog_sleep_tb;
   import wsc_pkg::*;
   // A short base count keeps the longest divided time-out near 8k cycles.
   localparam int TICKS = 8;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [13:0] reg_addr_in = 14'h0000;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_we_in = 1'b0;
   logic reg_re_in = 1'b0;
   logic [7:0] config_word_in = 8'h00;
   logic wdt_osc_in = 1'b0;
   logic master_clear_pin_n_in = 1'b1;
   logic kick_instr_in = 1'b0;
   logic sleep_instr_in = 1'b0;
   logic [7:0] irq_flags_in = 8'h00;
   logic [7:0] reg_rdata_out;
   logic device_reset_out, wdt_reset_cause_out, main_osc_en_out, phase_clk_en_out;
   logic io_hold_out, sleeping_out, wake_out, wake_vector_out, prefetch_out;
   logic prescaler_to_timer_out;
   logic [31:0] lfsr_q = 32'h000109fb;
   int fail_count = 0;
   int total_checks = 0;
   int ticks = 0;
   int resets = 0;
   int n;

   wsc_watchdog_sleep #(.WDT_BASE_TICKS(TICKS)) i_wsc_watchdog_sleep (
      .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in), .reg_re_in(reg_re_in),
      .reg_rdata_out(reg_rdata_out), .config_word_in(config_word_in),
      .wdt_osc_in(wdt_osc_in), .master_clear_pin_n_in(master_clear_pin_n_in),
      .kick_instr_in(kick_instr_in), .sleep_instr_in(sleep_instr_in),
      .irq_flags_in(irq_flags_in), .device_reset_out(device_reset_out),
      .wdt_reset_cause_out(wdt_reset_cause_out), .main_osc_en_out(main_osc_en_out),
      .phase_clk_en_out(phase_clk_en_out), .io_hold_out(io_hold_out),
      .sleeping_out(sleeping_out), .wake_out(wake_out), .wake_vector_out(wake_vector_out),
      .prefetch_out(prefetch_out), .prescaler_to_timer_out(prescaler_to_timer_out));

   always #5 clk_in = ~clk_in;
   // The watchdog oscillator has its own period, unrelated to the core clock.
   always #37 wdt_osc_in = ~wdt_osc_in;
   always @(posedge wdt_osc_in) ticks++;
   always @(posedge device_reset_out) resets++;

   // ==========================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_we_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_we_in <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string w);
      @(posedge clk_in);
      reg_re_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_re_in <= 1'b0;
      #1;
      check(reg_rdata_out & m, e, w);
   endtask
   task automatic instr(input logic slp);
      @(posedge clk_in);
      if (slp) sleep_instr_in <= 1'b1;
      else kick_instr_in <= 1'b1;
      @(posedge clk_in);
      sleep_instr_in <= 1'b0;
      kick_instr_in <= 1'b0;
      ticks = 0;
      #1;
   endtask
   task automatic do_reset(input logic [7:0] cfg);
      @(posedge clk_in);
      rst_in <= 1'b1;
      config_word_in <= cfg;
      repeat (15) @(posedge clk_in);
      rst_in <= 1'b0;
   endtask
   task automatic wait_wake(input int lim);
      for (int i = 0; i < lim && !wake_out; i++) begin
         @(posedge clk_in);
         #1;
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #900_000;
      fail_count++;
      $display("mismatch at %0t: run hung", $time);
      conclude();
   end

   // ==========================================================================
   // Scenarios
   initial begin
      do_reset(8'h00);
      rd(ADDR_STATUS, 8'h18, 8'h18, "status at power-up");
      rd(ADDR_IRQ_CTRL, 8'h80, 8'h00, "global enable");
      rd(ADDR_TIMER_OPTION, 8'hff, OPTION_RESET, "option");
      rd(ADDR_WAKE_EN, 8'hff, WAKE_EN_RESET, "wake enable");
      rd(14'h0050, 8'hff, 8'h00, "unmapped");
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'h18, 8'h18, "status read-only");
      wr(ADDR_TIMER_OPTION, 8'h08);
      repeat (200) @(posedge clk_in);
      check(8'(resets), 8'h00, "fuse off");
      rd(ADDR_WDT_STATE, 8'h80, 8'h00, "watchdog on");
      do_reset(8'h04);
      rd(ADDR_CONFIG_WORD, 8'hff, 8'h04, "config");
      repeat (6) begin
         lfsr_q = lfsr(lfsr_q);
         wr(ADDR_WAKE_EN, lfsr_q[7:0]);
         wr(ADDR_TIMER_OPTION, lfsr_q[15:8]);
         rd(ADDR_WAKE_EN, 8'hff, lfsr_q[7:0], "wake enable");
         check(8'(prescaler_to_timer_out), 8'(!lfsr_q[11]), "owner");
         instr(1'b0);
         rd(ADDR_TIMER_OPTION, 8'hff, lfsr_q[15:8], "option after kick");
         check(8'(prescaler_to_timer_out), 8'(!lfsr_q[11]), "owner after kick");
      end
      wr(ADDR_TIMER_OPTION, 8'h00);
      n = resets;
      repeat (12) begin
         repeat (30) @(posedge clk_in);
         instr(1'b0);
      end
      check(8'(resets - n), 8'h00, "kick holds off");
      for (int i = 0; i < 400 && !device_reset_out; i++) begin
         @(posedge clk_in);
         #1;
      end
      check(8'(ticks >= TICKS - 1 && ticks <= TICKS), 8'h01, "base time-out");
      check(8'({device_reset_out, wdt_reset_cause_out}), 8'h03, "watchdog reset");
      repeat (8) @(posedge clk_in);
      rd(ADDR_STATUS, 8'h18, 8'h08, "expiry flag");
      rd(ADDR_TIMER_OPTION, 8'hff, OPTION_RESET, "option after reset");
      wr(ADDR_WAKE_EN, 8'h30);
      @(posedge clk_in);
      irq_flags_in <= 8'h10;
      instr(1'b1);
      check(8'({sleeping_out, prefetch_out}), 8'h00, "pending sleep");
      rd(ADDR_STATUS, 8'h18, 8'h08, "pending status");
      irq_flags_in <= 8'h00;
      for (int g = 0; g < 2; g++) begin
         wr(ADDR_IRQ_CTRL, 8'(g << 7));
         wr(ADDR_WAKE_EN, 8'h3c);
         instr(1'b0);
         instr(1'b1);
         check(8'({prefetch_out, sleeping_out, io_hold_out, main_osc_en_out,
                   phase_clk_en_out}), 8'h1c, "sleep entry");
         rd(ADDR_STATUS, 8'h18, 8'h10, "asleep status");
         @(posedge clk_in);
         irq_flags_in <= 8'h0c;
         repeat (8) @(posedge clk_in);
         #1;
         check(8'(sleeping_out), 8'h01, "clocked source");
         @(posedge clk_in);
         irq_flags_in <= 8'h2c;
         wait_wake(4);
         check(8'({wake_out, wake_vector_out}), 8'(2 | g), "interrupt wake");
         @(posedge clk_in);
         irq_flags_in <= 8'h00;
         rd(ADDR_STATUS, 8'h18, 8'h10, "status after wake");
      end
      wr(ADDR_WAKE_EN, 8'h00);
      n = resets;
      for (int r = 0; r < 8; r++) begin
         wr(ADDR_TIMER_OPTION, 8'(8 | r));
         instr(1'b1);
         wait_wake((TICKS << r) * 8 + 40);
         check(8'(wake_out), 8'h01, "watchdog wake");
         check(8'(ticks >= (TICKS << r) - 1 && ticks <= (TICKS << r)), 8'h01,
               "divided time-out");
         rd(ADDR_STATUS, 8'h18, 8'h00, "wake status");
      end
      check(8'(resets - n), 8'h00, "no reset asleep");
      instr(1'b1);
      @(posedge clk_in);
      master_clear_pin_n_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      #1;
      check(8'({device_reset_out, sleeping_out}), 8'h02, "master clear");
      @(posedge clk_in);
      master_clear_pin_n_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      #1;
      check(8'(wdt_reset_cause_out), 8'h00, "cause cleared");
      rd(ADDR_STATUS, 8'h18, 8'h10, "status kept");
      conclude();
   end
endmodule // wsc_watchdog_sleep_tb
